// File: src/hub_seq_pkg.sv
// constants and types shared by both ends of the reset sequencing link
package hub_seq_pkg;

  // ********************************************************
  // timing
  // ********************************************************
  localparam int CLK_PERIOD_NS  = 100;
  localparam int CLOCK_VALID_US = 10;
  // least time, so round up to whole cycles
  localparam int CLOCK_VALID_CYC =
    (CLOCK_VALID_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CLOCK_VALID_LAST =
    CNT_W'(CLOCK_VALID_CYC - 1);
  // generated clocks toggle every CLK_HALF_LAST + 1 cycles
  localparam logic [1:0] CLK_HALF_LAST = 2'h1;
  // a clock with no edge for this many cycles counts as stopped
  localparam logic [3:0] ACT_WINDOW = 4'h8;

  // ********************************************************
  // widths, field positions, reset values
  // ********************************************************
  localparam int STRAP_W = 4;
  localparam int GAD_W   = 8;
  localparam logic [STRAP_W-1:0] STRAP_RST = 4'h0;
  localparam logic [GAD_W-1:0]   GAD_IDLE  = 8'hFF;
  localparam logic CFG_THROTTLE_RST = 1'h1;
  localparam logic CFG_IRQ_RST      = 1'h0;
  // device input synchroniser bit map
  localparam int SI_PG    = 0;
  localparam int SI_HCLK  = 1;
  localparam int SI_IOCLK = 2;
  localparam int SI_HOT_N = 3;
  localparam int SI_REQ_N = 4;
  localparam int SI_STRAP = 5;
  localparam int DEV_SYNC_W = SI_STRAP + STRAP_W;
  // host input synchroniser bit map
  localparam int HS_GNT_N = 0;
  localparam int HS_GAD   = 1;
  localparam int HOST_SYNC_W = HS_GAD + GAD_W;

  // ********************************************************
  // state machines
  // ********************************************************
  typedef enum logic [1:0] {
    GFX_IDLE    = 2'h0,
    GFX_TURN    = 2'h1,
    GFX_DRIVE   = 2'h3,
    GFX_RELEASE = 2'h2
  } gfx_state_t;

  typedef enum logic [2:0] {
    SEQ_OFF     = 3'h0,
    SEQ_CLKWAIT = 3'h1,
    SEQ_PGWAIT  = 3'h3,
    SEQ_RUN     = 3'h2,
    SEQ_WARM    = 3'h6
  } seq_state_t;

endpackage

// File: src/hub_seq_if.sv
// pins between the hub device and the platform sequencing end
`timescale 1ns/10ps
interface hub_seq_if;
  import hub_seq_pkg::*;

  logic               resetInN;
  logic               powerGood;
  logic               hostClockPair;
  logic               hostClockPairNeg;
  logic               ioClock66;
  logic               overTempInN;
  logic [STRAP_W-1:0] strapBits;
  logic               gfxReqN;
  logic               gfxGntN;
  logic               gfxGntOe;
  logic [GAD_W-1:0]   gadOut;
  logic               gadOe;
  logic               gntLine;
  logic [GAD_W-1:0]   gadLine;

  // pull-ups hold undriven graphics pins high
  assign gntLine = gfxGntOe ? gfxGntN : 1'h1;
  assign gadLine = gadOe ? gadOut : GAD_IDLE;

  modport device (
    input  resetInN, powerGood, hostClockPair, hostClockPairNeg,
    input  ioClock66, overTempInN, strapBits, gfxReqN,
    output gfxGntN, gfxGntOe, gadOut, gadOe
  );

  modport host (
    output resetInN, powerGood, hostClockPair, hostClockPairNeg,
    output ioClock66, overTempInN, strapBits, gfxReqN,
    input  gntLine, gadLine
  );
endinterface

// File: src/hub_seq_host.sv
// platform end: power, clock and reset sequencer plus graphics requester
`timescale 1ns/10ps
module hub_seq_host
  import hub_seq_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  hub_seq_if.host                 link,
  input  wire logic               sleepReq,
  input  wire logic               warmReq,
  input  wire logic [STRAP_W-1:0] strapDrive,
  input  wire logic               overTemp,
  input  wire logic               readReq,
  output logic      [GAD_W-1:0]   readData,
  output logic                    readValid,
  output logic                    powerReady
);

  // ********************************************************
  // sequencer
  // ********************************************************
  seq_state_t       seq_q, seq_d;
  logic [CNT_W-1:0] cnt_q;
  logic             pg_q, rstN_q;
  wire              cntDone = (cnt_q == CLOCK_VALID_LAST);

  // both clocks start together, so the host clock is valid long
  // before reset is released
  always_comb
  begin
    seq_d = seq_q;
    case (seq_q)
      SEQ_OFF:     if (!sleepReq) seq_d = SEQ_CLKWAIT;
      SEQ_CLKWAIT: if (cntDone) seq_d = SEQ_PGWAIT;    // R4 R5
      SEQ_PGWAIT:  if (cntDone) seq_d = SEQ_RUN;       // R6
      SEQ_RUN:
      begin
        if (sleepReq) seq_d = SEQ_OFF;                 // R8
        else if (warmReq) seq_d = SEQ_WARM;
      end
      SEQ_WARM:
      begin
        if (sleepReq) seq_d = SEQ_OFF;                 // R8
        else if (cntDone) seq_d = SEQ_RUN;
      end
      default:     seq_d = SEQ_OFF;
    endcase
  end

  // counter restarts on every state change
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      seq_q  <= SEQ_OFF;
      cnt_q  <= '0;
      pg_q   <= 1'h0;
      rstN_q <= 1'h0;
    end
    else
    begin
      seq_q  <= seq_d;
      cnt_q  <= (seq_d != seq_q) ? '0 : cnt_q + 1'h1;
      pg_q   <= (seq_d == SEQ_PGWAIT) || (seq_d == SEQ_RUN)
                || (seq_d == SEQ_WARM);                 // R4 R8
      rstN_q <= (seq_d == SEQ_RUN);                    // R6
    end
  end

  // ********************************************************
  // clock generation
  // ********************************************************
  logic [1:0] div_q;
  logic       clk_q;

  // clocks stand still while powered off; the first rising edge lands
  // with the wake-up, so the whole wait counts as clock-valid time
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || seq_d == SEQ_OFF)
    begin
      div_q <= 2'h0;
      clk_q <= 1'h0;
    end
    else if (seq_q == SEQ_OFF)
    begin
      div_q <= 2'h0;
      clk_q <= 1'h1;                                   // R5
    end
    else
    begin
      div_q <= (div_q == CLK_HALF_LAST) ? 2'h0 : div_q + 2'h1;
      if (div_q == CLK_HALF_LAST) clk_q <= ~clk_q;
    end
  end

  // ********************************************************
  // thermal alarm, straps, graphics requests
  // ********************************************************
  logic [STRAP_W-1:0]     strap_q;
  logic                   hot_q, reqN_q;
  logic [HOST_SYNC_W-1:0] s1_q, s2_q, s3_q, filt_q;
  wire  [HOST_SYNC_W-1:0] rawIn = {link.gadLine, link.gntLine};
  wire  gntF = ~filt_q[HS_GNT_N];

  // a level change counts once second and third stage agree
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s1_q   <= '1;
      s2_q   <= '1;
      s3_q   <= '1;
      filt_q <= '1;
    end
    else
    begin
      s1_q   <= rawIn;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
    end
  end

  // one read at a time; no locked sequences exist on this port
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      strap_q    <= STRAP_RST;
      hot_q      <= 1'h0;
      reqN_q     <= 1'h1;
      readData   <= GAD_IDLE;
      readValid  <= 1'h0;
      powerReady <= 1'h0;
    end
    else
    begin
      strap_q    <= strapDrive;
      hot_q      <= overTemp;                          // R9
      powerReady <= (seq_q == SEQ_RUN);
      readValid  <= 1'h0;
      if (!reqN_q && gntF)
      begin
        readData  <= filt_q[HS_GAD +: GAD_W];
        readValid <= 1'h1;
        reqN_q    <= 1'h1;                             // R13 R14
      end
      else if (readReq && reqN_q && !gntF && powerReady)
        reqN_q <= 1'h0;
    end
  end

  assign link.powerGood        = pg_q;
  assign link.resetInN         = rstN_q;
  assign link.ioClock66        = clk_q;
  assign link.hostClockPair    = clk_q;
  assign link.hostClockPairNeg = ~clk_q;
  assign link.overTempInN      = ~hot_q;
  assign link.strapBits        = strap_q;
  assign link.gfxReqN          = reqN_q;

endmodule

// File: src/hub_seq_device.sv
// hub device end: reset, power-good, strap, clock check and thermal logic
// Contract
// [R1] reset in clears core logic asynchronously
// [R2] graphics outputs float while reset in low
// [R3] reset in resets graphics port logic
// [R4] power good only after stable power, clock
// [R5] io clock valid 10us before power good
// [R6] host clock valid 10us before reset release
// [R7] straps latched on power good rising edge
// [R8] power good drops in suspend, relatches
// [R9] over-temp input held for whole condition
// [R10] over-temp throttles, interrupts, or both
// [R11] host domain runs from host clock pair
// [R12] graphics domain runs from io clock
// [R13] no locked cycles on graphics port
// [R14] graphics cycles follow PCI 2.1 signalling
// [R15] full reset restores every default; strapValue keeps its last latch until the next power good rise
// [R16] warm reset keeps configuration bits
// [R17] reset release synchronised per domain
`timescale 1ns/10ps
module hub_seq_device
  import hub_seq_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  hub_seq_if.device               link,
  input  wire logic               cfgWrite,
  input  wire logic               cfgThrottleEn,
  input  wire logic               cfgIrqEn,
  input  wire logic [GAD_W-1:0]   readData,
  output logic                    readDone,
  output logic                    hotThrottle,
  output logic                    hotIrq,
  output logic      [STRAP_W-1:0] strapValue,
  output logic                    strapValid,
  output logic                    warmReset,
  output logic                    hostDomainRun,
  output logic                    gfxDomainRun
);

  // ********************************************************
  // reset release synchroniser
  // ********************************************************
  logic [2:0] rstSync_q;
  wire        relDone = rstSync_q[2] & rstSync_q[1];
  wire        coreRst = sys_rst | ~relDone;

  // assertion is immediate, release waits for the chain to agree
  always_ff @(posedge sys_clk or negedge link.resetInN)
  begin
    if (!link.resetInN)
      rstSync_q <= 3'h0;                               // R1
    else
      rstSync_q <= {rstSync_q[1:0], 1'h1};             // R17
  end

  // ********************************************************
  // pin input synchronisers
  // ********************************************************
  logic [DEV_SYNC_W-1:0] s1_q, s2_q, s3_q, filt_q;
  // differential pair seen as one level: high only when the true leg is high and the negative leg low
  wire  hostDiff = link.hostClockPair & ~link.hostClockPairNeg;
  wire  [DEV_SYNC_W-1:0] rawIn = {link.strapBits, link.gfxReqN,
                                  link.overTempInN, link.ioClock66,
                                  hostDiff, link.powerGood};

  // a change counts once second and third stage agree
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      filt_q <= '0;
    end
    else
    begin
      s1_q   <= rawIn;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
    end
  end

  wire pgF   = filt_q[SI_PG];
  wire hotF  = ~filt_q[SI_HOT_N];
  wire reqF  = ~filt_q[SI_REQ_N];

  // ********************************************************
  // straps and sticky configuration
  // ********************************************************
  logic pgPrev_q;
  logic cfgThrottle_q, cfgIrq_q;
  wire  pgRise    = pgF & ~pgPrev_q;
  wire  fullReset = ~relDone & ~pgF;                   // R15

  // straps survive reset in, since they are taken while it is low
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      pgPrev_q   <= 1'h0;
      strapValue <= STRAP_RST;
      strapValid <= 1'h0;
      warmReset  <= 1'h0;
    end
    else
    begin
      pgPrev_q  <= pgF;
      // kept out of the pin reset, or it could never show a warm reset
      warmReset <= ~relDone & pgF;                     // R16
      if (pgRise)
      begin
        strapValue <= filt_q[SI_STRAP +: STRAP_W];     // R7
        strapValid <= 1'h1;
      end
      else if (!pgF)
        strapValid <= 1'h0;                            // R8
    end
  end

  // these bits ride through a warm reset; only a full reset clears
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || fullReset)
    begin
      cfgThrottle_q <= CFG_THROTTLE_RST;               // R15
      cfgIrq_q      <= CFG_IRQ_RST;
    end
    else if (cfgWrite && relDone)
    begin
      cfgThrottle_q <= cfgThrottleEn;                  // R16
      cfgIrq_q      <= cfgIrqEn;
    end
  end

  // ********************************************************
  // clock activity checks
  // ********************************************************
  logic [3:0] actCnt_q [2];
  logic [1:0] actPrev_q;
  wire  [1:0] clkF = {filt_q[SI_IOCLK], filt_q[SI_HCLK]};

  // a clock is trusted while it shows an edge inside the window
  always_ff @(posedge sys_clk or negedge link.resetInN)
  begin
    if (!link.resetInN)
    begin
      actPrev_q   <= 2'h0;
      actCnt_q[0] <= ACT_WINDOW;
      actCnt_q[1] <= ACT_WINDOW;
    end
    else
    begin
      actPrev_q <= clkF;
      for (int i = 0; i < 2; i++)
      begin
        if (coreRst || clkF[i] != actPrev_q[i])
          actCnt_q[i] <= (coreRst) ? ACT_WINDOW : 4'h0;
        else if (actCnt_q[i] != ACT_WINDOW)
          actCnt_q[i] <= actCnt_q[i] + 4'h1;
      end
    end
  end

  // domains leave reset only once released and clocked
  always_ff @(posedge sys_clk or negedge link.resetInN)
  begin
    if (!link.resetInN)
    begin
      hostDomainRun <= 1'h0;                           // R1
      gfxDomainRun  <= 1'h0;
    end
    else
    begin
      hostDomainRun <= relDone && actCnt_q[0] != ACT_WINDOW; // R11 R17
      gfxDomainRun  <= relDone && actCnt_q[1] != ACT_WINDOW; // R12 R17
    end
  end

  // ********************************************************
  // thermal response
  // ********************************************************
  logic hotPrev_q;

  // the alarm is a level, so throttle follows it while it lasts
  always_ff @(posedge sys_clk or negedge link.resetInN)
  begin
    if (!link.resetInN)
    begin
      hotPrev_q   <= 1'h0;
      hotThrottle <= 1'h0;
      hotIrq      <= 1'h0;
    end
    else if (coreRst)
    begin
      hotPrev_q   <= 1'h0;
      hotThrottle <= 1'h0;
      hotIrq      <= 1'h0;
    end
    else
    begin
      hotPrev_q   <= hotF;
      hotThrottle <= hotF & cfgThrottle_q;             // R10
      hotIrq      <= hotF & ~hotPrev_q & cfgIrq_q;     // R10
    end
  end

  // ********************************************************
  // graphics grant and data
  // ********************************************************
  gfx_state_t       gfx_q, gfx_d;
  logic [GAD_W-1:0] gad_q;

  // one idle turnaround cycle sits on each side of a drive; there
  // is no lock input, so every grant ends when the request drops
  always_comb
  begin
    gfx_d = gfx_q;
    case (gfx_q)
      GFX_IDLE:    if (reqF) gfx_d = GFX_TURN;
      GFX_TURN:    gfx_d = GFX_DRIVE;                  // R14
      GFX_DRIVE:   if (!reqF) gfx_d = GFX_RELEASE;     // R13
      GFX_RELEASE: gfx_d = GFX_IDLE;                   // R14
      default:     gfx_d = GFX_IDLE;
    endcase
    if (!gfxDomainRun) gfx_d = GFX_IDLE;               // R12
  end

  always_ff @(posedge sys_clk or negedge link.resetInN)
  begin
    if (!link.resetInN)
    begin
      gfx_q    <= GFX_IDLE;                            // R3
      gad_q    <= GAD_IDLE;
      readDone <= 1'h0;
    end
    else if (coreRst)
    begin
      gfx_q    <= GFX_IDLE;
      gad_q    <= GAD_IDLE;
      readDone <= 1'h0;
    end
    else
    begin
      gfx_q    <= gfx_d;
      readDone <= (gfx_q == GFX_DRIVE) && (gfx_d == GFX_RELEASE);
      if (gfx_q == GFX_TURN) gad_q <= readData;
    end
  end

  // enables fall straight off the pin, ahead of any clock edge, and
  // grant drive returns only once the release is synchronised
  assign link.gfxGntN  = ~(gfx_q == GFX_DRIVE);
  assign link.gfxGntOe = link.resetInN & relDone;      // R2 R17
  assign link.gadOut   = gad_q;
  assign link.gadOe    = link.resetInN && gfx_q == GFX_DRIVE; // R2

endmodule

// File: verification/hub_seq_properties.sv
// pin-level assertions on the link between the hub device and platform end
`timescale 1ns/10ps
module hub_seq_properties
  import hub_seq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic resetInN,
  input wire logic powerGood,
  input wire logic hostClockPair,
  input wire logic ioClock66,
  input wire logic gfxReqN,
  input wire logic gfxGntN,
  input wire logic gfxGntOe,
  input wire logic gadOe,
  input wire logic gntLine
);
  // ********************************************************
  // clock activity tracking
  // ********************************************************
  logic       ioPrev_q;
  logic       hostPrev_q;
  logic [3:0] ioIdle_q;
  logic [3:0] hostIdle_q;
  logic [7:0] ioAge_q;
  logic [7:0] hostAge_q;
  logic [3:0] ioIdle_d;
  logic [3:0] hostIdle_d;
  logic [7:0] ioAge_d;
  logic [7:0] hostAge_d;

  // idle counts saturate; an age restarts once its clock looks stopped
  assign ioIdle_d   = (ioClock66 != ioPrev_q) ? 4'h0 :
                      (ioIdle_q == 4'hF) ? ioIdle_q : ioIdle_q + 4'h1;
  assign hostIdle_d = (hostClockPair != hostPrev_q) ? 4'h0 :
                      (hostIdle_q == 4'hF) ? hostIdle_q : hostIdle_q + 4'h1;
  assign ioAge_d    = (ioIdle_q >= ACT_WINDOW) ? 8'h00 :
                      (ioAge_q == 8'hFF) ? ioAge_q : ioAge_q + 8'h01;
  assign hostAge_d  = (hostIdle_q >= ACT_WINDOW) ? 8'h00 :
                      (hostAge_q == 8'hFF) ? hostAge_q : hostAge_q + 8'h01;

  // registers for the activity trackers
  always_ff @(posedge sys_clk)
  begin
    ioPrev_q   <= sys_rst ? 1'h0 : ioClock66;
    hostPrev_q <= sys_rst ? 1'h0 : hostClockPair;
    ioIdle_q   <= sys_rst ? 4'h0 : ioIdle_d;
    hostIdle_q <= sys_rst ? 4'h0 : hostIdle_d;
    ioAge_q    <= sys_rst ? 8'h00 : ioAge_d;
    hostAge_q  <= sys_rst ? 8'h00 : hostAge_d;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  // ********************************************************
  // properties
  // ********************************************************
  sequence s_granted;
    ##[1:20] !gntLine;
  endsequence
  sequence s_released;
    ##[1:20] gntLine;
  endsequence

  property p_float_in_reset;
    !resetInN |-> !gadOe && !gfxGntOe;
  endproperty
  property p_io_clock_first;
    $rose(powerGood) |-> ioAge_q >= CLOCK_VALID_LAST;
  endproperty
  property p_host_clock_first;
    $rose(resetInN) |-> hostAge_q >= CLOCK_VALID_LAST;
  endproperty
  property p_no_run_without_pg;
    resetInN |-> powerGood;
  endproperty
  property p_release_synced;
    $rose(resetInN) |-> (!gadOe && !gfxGntOe) [*3];
  endproperty
  property p_grant_needs_req;
    $fell(gntLine) |-> !gfxReqN;
  endproperty
  property p_data_under_grant;
    gadOe |-> gfxGntOe && !gfxGntN;
  endproperty
  property p_drive_needs_clock;
    $rose(gadOe) |-> ioIdle_q < ACT_WINDOW;
  endproperty
  property p_grant_held;
    (!gntLine && !gfxReqN && resetInN) |=> !gntLine || !resetInN;
  endproperty
  property p_read_cycle;
    $fell(gfxReqN) && resetInN |-> s_granted ##0 s_released;
  endproperty

  a_float_in_reset: assert property (p_float_in_reset)
    else $error("graphics pins driven during reset");
  a_io_clock_first: assert property (p_io_clock_first)
    else $error("power good rose too soon after io clock");
  a_host_clock_first: assert property (p_host_clock_first)
    else $error("reset released too soon after host clock");
  a_no_run_without_pg: assert property (p_no_run_without_pg)
    else $error("reset released while power good low");
  a_release_synced: assert property (p_release_synced)
    else $error("graphics pins driven right at reset release");
  a_grant_needs_req: assert property (p_grant_needs_req)
    else $error("grant without request");
  a_data_under_grant: assert property (p_data_under_grant)
    else $error("data driven without grant");
  a_drive_needs_clock: assert property (p_drive_needs_clock)
    else $error("graphics drive with io clock stopped");
  a_grant_held: assert property (p_grant_held)
    else $error("grant dropped while request held");
  a_read_cycle: assert property (p_read_cycle)
    else $error("read request not granted and released in time");

  c_read: cover property (p_read_cycle);
endmodule

// File: verification/tb_hub_reset_clock_sequencing.sv
// testbench joining both ends of the reset sequencing link
`timescale 1ns/10ps
`define CHK(got, exp) \
  checked++; \
  if ((got) !== (exp)) \
  begin \
    failures++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
  end
`define WAIT_UNTIL(cond, lim) \
  waitCnt = 0; \
  while (((cond) !== 1'b1) && waitCnt < (lim)) \
  begin \
    @(negedge sys_clk); \
    waitCnt++; \
  end \
  if ((cond) !== 1'b1) \
  begin \
    failures++; \
    $display("[FAIL] t=%0t timeout got=%0h exp=%0h", $time, 0, 1); \
    give_verdict(); \
  end
module tb_hub_reset_clock_sequencing
  import hub_seq_pkg::*;
;
  logic               sys_clk;
  logic               sys_rst;
  logic               sleepReq;
  logic               warmReq;
  logic               overTemp;
  logic               readReq;
  logic               cfgWrite;
  logic               cfgThrottleEn;
  logic               cfgIrqEn;
  logic [STRAP_W-1:0] strapDrive;
  logic [STRAP_W-1:0] strapValue;
  logic [GAD_W-1:0]   devData;
  logic [GAD_W-1:0]   hostData;
  logic [GAD_W-1:0]   lastData;
  logic               readValid;
  logic               powerReady;
  logic               readDone;
  logic               hotThrottle;
  logic               hotIrq;
  logic               strapValid;
  logic               warmReset;
  logic               hostDomainRun;
  logic               gfxDomainRun;
  int                 failures = 0;
  int                 checked = 0;
  int                 waitCnt;
  int                 pgWait = 0;
  int                 rsWait = 0;
  int                 irqCnt = 0;
  int                 validCnt = 0;
  int                 doneCnt = 0;

  hub_seq_if u_hub_seq_if ();

  hub_seq_host u_hub_seq_host (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .link       (u_hub_seq_if),
    .sleepReq   (sleepReq),
    .warmReq    (warmReq),
    .strapDrive (strapDrive),
    .overTemp   (overTemp),
    .readReq    (readReq),
    .readData   (hostData),
    .readValid  (readValid),
    .powerReady (powerReady)
  );

  hub_seq_device u_hub_seq_device (
    .sys_clk       (sys_clk),
    .sys_rst       (sys_rst),
    .link          (u_hub_seq_if),
    .cfgWrite      (cfgWrite),
    .cfgThrottleEn (cfgThrottleEn),
    .cfgIrqEn      (cfgIrqEn),
    .readData      (devData),
    .readDone      (readDone),
    .hotThrottle   (hotThrottle),
    .hotIrq        (hotIrq),
    .strapValue    (strapValue),
    .strapValid    (strapValid),
    .warmReset     (warmReset),
    .hostDomainRun (hostDomainRun),
    .gfxDomainRun  (gfxDomainRun)
  );

  hub_seq_properties u_hub_seq_properties (
    .sys_clk       (sys_clk),
    .sys_rst       (sys_rst),
    .resetInN      (u_hub_seq_if.resetInN),
    .powerGood     (u_hub_seq_if.powerGood),
    .hostClockPair (u_hub_seq_if.hostClockPair),
    .ioClock66     (u_hub_seq_if.ioClock66),
    .gfxReqN       (u_hub_seq_if.gfxReqN),
    .gfxGntN       (u_hub_seq_if.gfxGntN),
    .gfxGntOe      (u_hub_seq_if.gfxGntOe),
    .gadOe         (u_hub_seq_if.gadOe),
    .gntLine       (u_hub_seq_if.gntLine)
  );

  // 10 MHz system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // count one-cycle pulses; values read here are those before the edge
  always @(posedge sys_clk)
  begin
    irqCnt <= irqCnt + int'(hotIrq === 1'b1);
    doneCnt <= doneCnt + int'(readDone === 1'b1);
    if (readValid === 1'b1)
      lastData <= hostData;
    validCnt <= validCnt + int'(readValid === 1'b1);
  end

  // cycles spent before power good, then before reset release
  always @(negedge sys_clk)
  begin
    if (!sys_rst && u_hub_seq_if.powerGood !== 1'b1)
      pgWait++;
    if (u_hub_seq_if.powerGood === 1'b1 && u_hub_seq_if.resetInN !== 1'b1)
      rsWait++;
  end

  task give_verdict();
    $display("checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // one graphics read; the next may start only once grant is back high
  task doRead(input logic [GAD_W-1:0] val);
    int v0;
    int d0;
    begin
      v0 = validCnt;
      d0 = doneCnt;
      devData = val;
      // hold until taken: the host drops a request silently while its
      // filtered grant still shows the previous read
      readReq = 1'b1;
      `WAIT_UNTIL(!u_hub_seq_if.gfxReqN, 20)
      readReq = 1'b0;
      `WAIT_UNTIL(validCnt != v0, 40)
      `CHK(lastData, val);
      `WAIT_UNTIL(doneCnt != d0 && u_hub_seq_if.gntLine, 40)
    end
  endtask

  task setCfg(input logic th, input logic irq);
    cfgThrottleEn = th;
    cfgIrqEn = irq;
    cfgWrite = 1'b1;
    @(negedge sys_clk);
    cfgWrite = 1'b0;
  endtask

  // the filter settles in about five cycles, twelve leaves margin
  task doHot(input logic expTh, input int expIrq);
    int i0;
    begin
      i0 = irqCnt;
      overTemp = 1'b1;
      repeat (12) @(negedge sys_clk);
      `CHK(hotThrottle, expTh);
      `CHK(irqCnt - i0, expIrq);
      overTemp = 1'b0;
      repeat (12) @(negedge sys_clk);
      `CHK(hotThrottle, 1'b0);
    end
  endtask

  // ********************************************************
  // main sequence
  // ********************************************************
  initial
  begin
    sys_rst = 1'b1;
    sleepReq = 1'b0;
    warmReq = 1'b0;
    overTemp = 1'b0;
    readReq = 1'b0;
    cfgWrite = 1'b0;
    cfgThrottleEn = 1'b0;
    cfgIrqEn = 1'b0;
    strapDrive = 4'hA;
    devData = 8'h00;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    `WAIT_UNTIL(powerReady, 400)
    `CHK(pgWait >= 100, 1'b1);
    `CHK(rsWait >= 100, 1'b1);
    // domains run only after release sync and a seen clock edge
    repeat (8) @(negedge sys_clk);
    `CHK(strapValue, 4'hA);
    `CHK(strapValid, 1'b1);
    `CHK(hostDomainRun, 1'b1);
    `CHK(gfxDomainRun, 1'b1);
    `CHK(warmReset, 1'b0);
    strapDrive = 4'h5;
    doRead(8'h00);
    doRead(8'hFF);
    doRead(8'h5A);
    `CHK(strapValue, 4'hA);
    // default config after power-up, then every mode
    doHot(1'b1, 0);
    setCfg(1'b1, 1'b1);
    doHot(1'b1, 1);
    setCfg(1'b0, 1'b1);
    doHot(1'b0, 1);
    setCfg(1'b0, 1'b0);
    doHot(1'b0, 0);
    // warm reset lands in the middle of a read data phase
    devData = 8'h3C;
    readReq = 1'b1;
    @(negedge sys_clk);
    readReq = 1'b0;
    `WAIT_UNTIL(u_hub_seq_if.gadOe, 40)
    warmReq = 1'b1;
    `WAIT_UNTIL(!u_hub_seq_if.resetInN, 10)
    warmReq = 1'b0;
    `CHK(u_hub_seq_if.gadOe, 1'b0);
    `CHK(u_hub_seq_if.gntLine, 1'b1);
    `CHK(u_hub_seq_if.gadLine, GAD_IDLE);
    repeat (4) @(negedge sys_clk);
    `CHK(warmReset, 1'b1);
    `CHK(strapValid, 1'b1);
    `CHK(strapValue, 4'hA);
    `CHK(gfxDomainRun, 1'b0);
    // suspend, new straps, wake: a full reset
    sleepReq = 1'b1;
    `WAIT_UNTIL(!u_hub_seq_if.powerGood, 10)
    repeat (8) @(negedge sys_clk);
    `CHK(strapValid, 1'b0);
    `CHK(warmReset, 1'b0);
    strapDrive = 4'h3;
    sleepReq = 1'b0;
    pgWait = 0;
    rsWait = 0;
    `WAIT_UNTIL(powerReady, 400)
    `CHK(rsWait >= 100, 1'b1);
    repeat (4) @(negedge sys_clk);
    `CHK(strapValue, 4'h3);
    doHot(1'b1, 0);
    doRead(8'hC3);
    give_verdict();
  end
endmodule
